// >>> bench/odac_host.sv
// host-side model of the serial link: frames, link clock and data-out capture
`timescale 1ns/1ps
module odac_host (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    // ==========================================================
    // frame engine
    logic [15:0] q_lo; // data out seen in each low phase
    logic [15:0] q_hi; // data out seen in each high phase
    logic q_rel; // data out at the moment of release
    // idle state: clock parked low, nothing selected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // sends n bits msb first; split pauses after 4 and 8 bits
    task automatic send(input logic [19:0] bits, input int n, input bit split);
        cs_n = 1'b0;
        #41.3; // odd offset keeps link edges off the system clock phase
        for (int i = n - 1; i >= 0; i--) begin // whole word every frame
            din = bits[i];
            #8 sclk = 1'b1; // data taken on this rise
            #7 q_hi = {q_hi[14:0], dout};
            #8 sclk = 1'b0;
            #7 q_lo = {q_lo[14:0], dout};
            // nibble gaps: clock stands still and low
            if (split && (i == n - 4 || i == n - 8)) begin
                #60;
            end
        end
        #15 cs_n = 1'b1;
        din = ~din; // released line must not keep the last value
        q_rel = dout;
        // stray clocks while deselected must be ignored
        repeat (2) begin
            #10 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
    endtask
endmodule // odac_host

// >>> bench/testbench.sv
// self-checking bench of the octal dac serial command port
`timescale 1ns/1ps
module testbench;
    import odac_pkg::*;
    // ==========================================================
    // pins, counters and reference model
    logic clock;
    logic rst_n;
    logic ce;
    logic load_strobe_n;
    logic sclk, cs_n, din, dout, dout_mode;
    logic [ODAC_CHANNELS-1:0][ODAC_CODE_W-1:0] channel_output;
    logic [ODAC_CHANNELS-1:0] buffer_enable;
    int error_cnt = 0;
    int check_count = 0;
    logic [7:0] inp_m [8]; // expected input registers
    logic [7:0] dac_m [8]; // expected dac registers
    logic [7:0] en_m; // expected buffer enables
    logic mode_m; // expected data-out edge mode
    logic mode_old; // mode before the last command, for link sync lag
    logic [63:0] hist; // last 64 bits shifted in, newest at bit 0
    // ==========================================================
    // design and host
    odac_port i_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .load_strobe_n(load_strobe_n),
        .channel_output(channel_output), .buffer_enable(buffer_enable),
        .dout_mode(dout_mode));
    odac_host i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    // system clock, 5 ns
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // ==========================================================
    // helpers
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // works out the register effect of one decoded word
    task automatic apply(input logic [15:0] w);
        logic [7:0] d;
        logic [2:0] ch;
        d = w[ODAC_DATA_HI:ODAC_DATA_LO];
        ch = w[ODAC_ADDR_HI:ODAC_ADDR_LO];
        mode_old = mode_m;
        case (w[ODAC_CMD_HI:ODAC_CMD_LO])
            ODAC_CMD_CLEAR: begin
                foreach (inp_m[i]) inp_m[i] = 8'h00;
                dac_m = inp_m;
                en_m = 8'hFF;
            end
            ODAC_CMD_SHDN: en_m = d;
            ODAC_CMD_EDGE: begin
                mode_m = w[ODAC_EDGE_BIT];
                dac_m = inp_m;
            end
            ODAC_CMD_ALL: begin
                foreach (dac_m[i]) dac_m[i] = d;
                en_m = 8'hFF;
            end
            ODAC_CMD_INPUT: inp_m[ch] = d;
            ODAC_CMD_BOTH: begin
                inp_m[ch] = d;
                dac_m[ch] = d;
                en_m = 8'hFF;
            end
            ODAC_CMD_LOAD: dac_m = inp_m;
            default: ; // pass-through leaves all alone
        endcase
        if (!load_strobe_n) begin // transparent while strobe low
            dac_m = inp_m;
        end
    endtask
    task automatic cmp_regs();
        logic [7:0][7:0] e;
        foreach (dac_m[i]) e[i] = dac_m[i];
        check("channel_output", channel_output, e);
        check("buffer_enable", buffer_enable, en_m);
        check("dout_mode", dout_mode, mode_m);
    endtask
    // one frame of n bits (16 or 20), then data-out and register checks
    task automatic frame(input logic [15:0] w, input int n, input bit split);
        logic [19:0] b;
        logic dout_end;
        b = {(n > 16) ? 4'($urandom) : 4'h0, w};
        i_host.send(b, n, split);
        dout_end = i_host.q_rel;
        check("dout_release", dout, dout_end);
        hist = (hist << n) | 64'(b);
        check("dout_lo", i_host.q_lo, hist[31:16]);
        // skip the edge check right after a mode change: it syncs late
        if (mode_m === mode_old) begin
            check("dout_hi", i_host.q_hi, mode_m ? hist[31:16] : hist[32:17]);
        end
        repeat (20) @(posedge clock);
        #1;
        apply(w); // last sixteen bits decode
        check("dout_hold", dout, dout_end);
        cmp_regs();
    endtask
    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] w;
        rst_n = 1'b0;
        ce = 1'b1;
        load_strobe_n = 1'b1;
        void'($urandom(32'hAEF8));
        foreach (inp_m[i]) inp_m[i] = 8'h00;
        dac_m = inp_m;
        en_m = 8'hFF;
        mode_m = ODAC_MODE_FALL;
        mode_old = ODAC_MODE_FALL;
        hist = 64'h0;
        repeat (16) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        cmp_regs();
        check("dout_reset", dout, 1'b0);
        frame(16'hE300, 16, 1'b0); // ignored top bits set, rising mode
        // every code once, then random words, long frames now and then
        for (int i = 0; i < 48; i++) begin
            w = 16'($urandom);
            if (i < 8) begin
                w[ODAC_CMD_HI:ODAC_CMD_LO] = 3'(i);
            end
            frame(w, (i % 7 == 6) ? 20 : 16, 1'($urandom));
        end
        frame(16'h0300, 16, 1'b0); // back to falling mode
        frame(16'h1DA5, 16, 1'b0); // input only, dacs untouched
        load_strobe_n = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        dac_m = inp_m; // strobe copies all inputs
        cmp_regs();
        frame(16'h35C3, 16, 1'b1); // input write flows through
        load_strobe_n = 1'b1;
        ce = 1'b0; // idle freeze must not disturb anything
        repeat (4) @(posedge clock);
        #1 ce = 1'b1;
        frame(16'h0700, 16, 1'b0);
        end_sim();
    end
    // hang guard
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
endmodule // testbench

// >>> core/odac_link.sv
// serial shift register and data-out logic, clocked by the link clock
`timescale 1ns/1ps
module odac_link (
    // link clock and reset
    input wire logic sclk,
    input wire logic rst_n,
    // serial pins
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // towards the command engine
    input wire logic mode_sel,
    output logic [odac_pkg::ODAC_WORD_W-1:0] shift_word
);
    import odac_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [ODAC_WORD_W-1:0] sr; // shift register
        logic dout_rise;            // rising-edge copy of the msb
        logic mode_s1;              // mode synchroniser, first stage
        logic mode_s2;              // mode synchroniser, second stage
    } odac_link_s;

    odac_link_s r_r;
    odac_link_s r_nxt;
    logic dout_fall_r;              // falling-edge copy, half cycle later

    // next state: everything moves only inside a frame
    always_comb begin
        r_nxt = r_r;
        if (!cs_n) begin
            // mode moves only in a frame, so stray clocks cannot flip data out
            r_nxt.mode_s1 = mode_sel;
            r_nxt.mode_s2 = r_r.mode_s1;
            // msb leaves before the shift, so a bit appears 16 edges later
            r_nxt.dout_rise = r_r.sr[ODAC_WORD_W-1];
            r_nxt.sr = {r_r.sr[ODAC_WORD_W-2:0], din};
        end
    end

    // rising-edge register, cleared at power-on
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '{sr: ODAC_RST_WORD, dout_rise: 1'b0, mode_s1: ODAC_MODE_FALL,
                     mode_s2: ODAC_MODE_FALL};
        end else begin
            r_r <= r_nxt;
        end
    end

    // falling-edge stage adds the half cycle of mode 0
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_fall_r <= 1'b0;
        end else if (!cs_n) begin
            dout_fall_r <= r_r.dout_rise;
        end
    end

    // output is always driven, never floats
    assign dout = r_r.mode_s2 ? r_r.dout_rise : dout_fall_r;
    assign shift_word = r_r.sr;

    // ==========================================================
    // checks
    property p_shift;
        @(posedge sclk) disable iff (!rst_n)
        !cs_n |=> r_r.sr == {$past(r_r.sr[ODAC_WORD_W-2:0]), $past(din)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift register missed a bit");

    property p_hold;
        @(posedge sclk) disable iff (!rst_n)
        cs_n |=> $stable(r_r.sr) && $stable(r_r.dout_rise) && $stable(r_r.mode_s2);
    endproperty
    a_hold: assert property (p_hold) else $error("link moved with select high");

    property p_lag;
        @(posedge sclk) disable iff (!rst_n)
        !cs_n ##1 !cs_n |-> r_r.dout_rise == $past(r_r.sr[ODAC_WORD_W-1]);
    endproperty
    a_lag: assert property (p_lag) else $error("data out lag wrong");
endmodule // odac_link

// >>> core/odac_pkg.sv
// shared constants and types of the octal dac serial command port
package odac_pkg;
    // ==========================================================
    // sizes
    localparam int ODAC_CHANNELS = 8;
    localparam int ODAC_CODE_W = 8;
    localparam int ODAC_WORD_W = 16;
    localparam int ODAC_SYNC_STAGES = 2;
    // ==========================================================
    // field positions inside the 16-bit word (top two bits ignored)
    localparam int ODAC_ADDR_HI = 13;
    localparam int ODAC_ADDR_LO = 11;
    localparam int ODAC_CMD_HI = 10;
    localparam int ODAC_CMD_LO = 8;
    localparam int ODAC_DATA_HI = 7;
    localparam int ODAC_DATA_LO = 0;
    localparam int ODAC_EDGE_BIT = 13;
    // ==========================================================
    // command codes
    localparam logic [2:0] ODAC_CMD_PASS = 3'h0;
    localparam logic [2:0] ODAC_CMD_CLEAR = 3'h1;
    localparam logic [2:0] ODAC_CMD_SHDN = 3'h2;
    localparam logic [2:0] ODAC_CMD_EDGE = 3'h3;
    localparam logic [2:0] ODAC_CMD_ALL = 3'h4;
    localparam logic [2:0] ODAC_CMD_INPUT = 3'h5;
    localparam logic [2:0] ODAC_CMD_BOTH = 3'h6;
    localparam logic [2:0] ODAC_CMD_LOAD = 3'h7;
    // ==========================================================
    // output edge modes and reset values
    localparam logic ODAC_MODE_FALL = 1'b0;
    localparam logic ODAC_MODE_RISE = 1'b1;
    localparam logic [7:0] ODAC_RST_CODE = 8'h00;
    localparam logic [7:0] ODAC_RST_BUF_EN = 8'hFF;
    localparam logic [15:0] ODAC_RST_WORD = 16'h0000;
    localparam logic ODAC_RST_PIN = 1'b1;
    // ==========================================================
    // command engine states
    typedef enum logic [0:0] {
        ODAC_ST_IDLE,
        ODAC_ST_EXEC
    } odac_state_e;
endpackage

// >>> core/odac_port.sv
// octal dac serial command port: frame capture, decode and channel registers
//
// Behaviour
// - low load strobe copies input to dac
// - shift while selected, execute on select rise
// - sample data in on rising link clock
// - power-on clears everything, falling-edge output mode
// - sixteen-bit words msb first, top two ignored
// - data out lags sixteen cycles, edge by mode
// - data out always driven, never floats
// - select high ignores link, holds data out
// - fields: ignored, address, command, data byte
// - code 000 changes nothing
// - code 001 clears all input and dac
// - code 010 shutdown, zero bits disable buffers
// - code 011 latches output edge from top address bit
// - code 100 writes byte to all dacs
// - code 101 writes addressed input register only
// - code 110 writes addressed input and dac
// - code 111 copies all inputs to dacs
// - old contents shift out while new enter
// - lag sixteen and half falling, sixteen rising
// - edge commands also copy inputs to dacs
// - dac registers transparent while strobe held low
// - clear, load-all, load-both leave shutdown
`timescale 1ns/1ps
module odac_port #(
    parameter int N_CH = odac_pkg::ODAC_CHANNELS,
    parameter int SYNC = odac_pkg::ODAC_SYNC_STAGES
) (
    // system clock, reset and enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // serial link from the host
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // asynchronous load strobe
    input wire logic load_strobe_n,
    // channel codes and output buffer enables
    output logic [N_CH-1:0][odac_pkg::ODAC_CODE_W-1:0] channel_output,
    output logic [N_CH-1:0] buffer_enable,
    // status
    output logic dout_mode
);
    import odac_pkg::*;

    // ==========================================================
    // elaboration checks
    // the address field is three bits wide, so exactly eight channels
    if (N_CH != ODAC_CHANNELS) begin : g_bad_ch
        $error("odac_port serves exactly eight channels");
    end
    // the synchronisers below are built with two stages
    if (SYNC != 2) begin : g_bad_sync
        $error("odac_port synchronisers have two stages");
    end

    // ==========================================================
    // state of the command engine
    typedef struct packed {
        odac_state_e st;                        // idle or executing
        logic cs_s1;                            // select sync, first stage
        logic cs_s2;                            // select sync, second stage
        logic cs_d;                             // delayed copy for edge find
        logic ld_s1;                            // strobe sync, first stage
        logic ld_s2;                            // strobe sync, second stage
        logic [ODAC_WORD_W-1:0] word;           // captured frame
        logic [N_CH-1:0][ODAC_CODE_W-1:0] inreg;  // input registers
        logic [N_CH-1:0][ODAC_CODE_W-1:0] dacreg; // dac registers
        logic [N_CH-1:0] buf_en;                // buffer enables
        logic mode;                             // data-out edge mode
    } odac_core_s;

    odac_core_s r_r;
    odac_core_s r_nxt;

    // link-side word, stable while select is high
    logic [ODAC_WORD_W-1:0] link_word;

    // fields of the captured word
    logic [2:0] cmd_w;                     // command code bits
    logic [2:0] chan_w;                    // channel select bits
    logic [ODAC_CODE_W-1:0] code_w;        // code byte
    logic edge_w;                          // top address bit
    logic cs_rise_w;                       // end of frame seen

    // ==========================================================
    // link side runs on the host's clock
    odac_link u_link (
        .sclk(sclk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .mode_sel(r_r.mode),
        .shift_word(link_word)
    );

    // ==========================================================
    // field split; the two top bits are never looked at
    assign cmd_w = r_r.word[ODAC_CMD_HI:ODAC_CMD_LO];
    assign chan_w = r_r.word[ODAC_ADDR_HI:ODAC_ADDR_LO];
    assign code_w = r_r.word[ODAC_DATA_HI:ODAC_DATA_LO];
    assign edge_w = r_r.word[ODAC_EDGE_BIT];

    // select rise after the two-flop synchroniser
    assign cs_rise_w = r_r.cs_s2 && !r_r.cs_d;

    // ==========================================================
    // next-state logic
    // transparency is applied first, so a command in the same cycle
    // wins; its input write then reaches the dac one cycle later
    always_comb begin
        r_nxt = r_r;
        // synchronisers: first stage feeds only the second
        r_nxt.cs_s1 = cs_n;
        r_nxt.cs_s2 = r_r.cs_s1;
        r_nxt.cs_d = r_r.cs_s2;
        r_nxt.ld_s1 = load_strobe_n;
        r_nxt.ld_s2 = r_r.ld_s1;
        // strobe held low: dac registers follow the inputs
        if (!r_r.ld_s2) begin
            r_nxt.dacreg = r_r.inreg;
        end
        case (r_r.st)
            ODAC_ST_IDLE: begin
                // select is high, so the word is quiet here even with stray link clocks;
                // only the last sixteen bits of the frame remain
                if (cs_rise_w) begin
                    r_nxt.word = link_word;
                    r_nxt.st = ODAC_ST_EXEC;
                end
            end
            ODAC_ST_EXEC: begin
                r_nxt.st = ODAC_ST_IDLE;
                case (cmd_w)
                    ODAC_CMD_PASS: begin
                        // word only travelled through the shifter
                        r_nxt.st = ODAC_ST_IDLE;
                    end
                    ODAC_CMD_CLEAR: begin
                        for (int i = 0; i < N_CH; i++) begin
                            r_nxt.inreg[i] = ODAC_RST_CODE;
                            r_nxt.dacreg[i] = ODAC_RST_CODE;
                        end
                        r_nxt.buf_en = ODAC_RST_BUF_EN;
                    end
                    ODAC_CMD_SHDN: begin
                        // a zero bit turns that channel's buffer off
                        r_nxt.buf_en = code_w;
                    end
                    ODAC_CMD_EDGE: begin
                        r_nxt.mode = edge_w;
                        r_nxt.dacreg = r_r.inreg;
                    end
                    ODAC_CMD_ALL: begin
                        // address field is ignored here
                        for (int i = 0; i < N_CH; i++) begin
                            r_nxt.dacreg[i] = code_w;
                        end
                        r_nxt.buf_en = ODAC_RST_BUF_EN;
                    end
                    ODAC_CMD_INPUT: begin
                        r_nxt.inreg[chan_w] = code_w;
                    end
                    ODAC_CMD_BOTH: begin
                        r_nxt.inreg[chan_w] = code_w;
                        r_nxt.dacreg[chan_w] = code_w;
                        r_nxt.buf_en = ODAC_RST_BUF_EN;
                    end
                    default: begin
                        // software load, same as the strobe
                        r_nxt.dacreg = r_r.inreg;
                    end
                endcase
            end
            default: begin
                r_nxt.st = ODAC_ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register; the enable freezes the whole engine
    // note: the link side keeps running on its own clock regardless
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_r.st <= ODAC_ST_IDLE;
            r_r.cs_s1 <= ODAC_RST_PIN;
            r_r.cs_s2 <= ODAC_RST_PIN;
            r_r.cs_d <= ODAC_RST_PIN;
            r_r.ld_s1 <= ODAC_RST_PIN;
            r_r.ld_s2 <= ODAC_RST_PIN;
            r_r.word <= ODAC_RST_WORD;
            r_r.inreg <= '0;
            r_r.dacreg <= '0;
            r_r.buf_en <= ODAC_RST_BUF_EN;
            r_r.mode <= ODAC_MODE_FALL;
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    // ==========================================================
    // outputs straight from registers
    assign channel_output = r_r.dacreg;
    assign buffer_enable = r_r.buf_en;
    assign dout_mode = r_r.mode;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_exec;
        ce && cs_rise_w && r_r.st == ODAC_ST_IDLE |=>
            r_r.st == ODAC_ST_EXEC && r_r.word == $past(link_word);
    endproperty
    a_exec: assert property (p_exec) else $error("frame end not executed");

    property p_pass;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_PASS && r_r.ld_s2 |=>
            $stable(r_r.inreg) && $stable(r_r.dacreg) && $stable(r_r.buf_en);
    endproperty
    a_pass: assert property (p_pass) else $error("pass-through changed state");

    property p_clear;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_CLEAR |=>
            r_r.inreg == '0 && r_r.dacreg == '0 && r_r.buf_en == ODAC_RST_BUF_EN;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");

    property p_shdn;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_SHDN |=>
            r_r.buf_en == $past(code_w);
    endproperty
    a_shdn: assert property (p_shdn) else $error("shutdown mask wrong");

    property p_edge;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_EDGE |=>
            r_r.mode == $past(edge_w) && r_r.dacreg == $past(r_r.inreg);
    endproperty
    a_edge: assert property (p_edge) else $error("edge command wrong");

    property p_all;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_ALL |=>
            r_r.dacreg[0] == $past(code_w) && r_r.dacreg[N_CH-1] == $past(code_w)
            && r_r.buf_en == ODAC_RST_BUF_EN;
    endproperty
    a_all: assert property (p_all) else $error("load-all wrong");

    property p_input;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_INPUT && r_r.ld_s2 |=>
            r_r.inreg[$past(chan_w)] == $past(code_w) && $stable(r_r.dacreg);
    endproperty
    a_input: assert property (p_input) else $error("input write wrong");

    property p_both;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_BOTH |=>
            r_r.dacreg[$past(chan_w)] == $past(code_w)
            && r_r.inreg[$past(chan_w)] == $past(code_w);
    endproperty
    a_both: assert property (p_both) else $error("input and dac write wrong");

    property p_load;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_LOAD |=>
            r_r.dacreg == $past(r_r.inreg);
    endproperty
    a_load: assert property (p_load) else $error("software load wrong");

    property p_strobe;
        ce && !r_r.ld_s2 && r_r.st == ODAC_ST_IDLE |=> r_r.dacreg == $past(r_r.inreg);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe copy missing");

    // ==========================================================
    // holding checks: nothing moves outside its own command
    // the write checks above cannot see a decode that writes too much,
    // so shutdown, edge, input and load commands also have their untouched state pinned down here
    property p_freeze;
        !ce |=> $stable(r_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("engine moved while disabled");

    property p_exec_once;
        ce && r_r.st == ODAC_ST_EXEC |=> r_r.st == ODAC_ST_IDLE;
    endproperty
    a_exec_once: assert property (p_exec_once) else $error("command ran twice");

    property p_word_hold;
        ce && !(cs_rise_w && r_r.st == ODAC_ST_IDLE) |=> $stable(r_r.word);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word moved");

    property p_inreg_hold;
        ce && r_r.st == ODAC_ST_IDLE |=> $stable(r_r.inreg);
    endproperty
    a_inreg_hold: assert property (p_inreg_hold) else $error("input moved");

    property p_buf_hold;
        ce && r_r.st == ODAC_ST_IDLE |=> $stable(r_r.buf_en);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("enable moved");

    property p_mode_hold;
        ce && !(r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_EDGE) |=> $stable(r_r.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

    property p_shdn_keep;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_SHDN && r_r.ld_s2 |=>
            $stable(r_r.dacreg) && $stable(r_r.inreg);
    endproperty
    a_shdn_keep: assert property (p_shdn_keep) else $error("shutdown wrote codes");

    property p_both_on;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_BOTH |=>
            r_r.buf_en == ODAC_RST_BUF_EN;
    endproperty
    a_both_on: assert property (p_both_on) else $error("still shut down");

    property p_load_keep;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_LOAD |=>
            $stable(r_r.inreg) && $stable(r_r.buf_en);
    endproperty
    a_load_keep: assert property (p_load_keep) else $error("load touched inputs");

    property p_edge_keep;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_EDGE |=>
            $stable(r_r.inreg) && $stable(r_r.buf_en);
    endproperty
    a_edge_keep: assert property (p_edge_keep) else $error("edge touched inputs");

    property p_input_keep;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_INPUT |=>
            $stable(r_r.buf_en) && $stable(r_r.mode);
    endproperty
    a_input_keep: assert property (p_input_keep) else $error("input write spilled");

    property p_all_full;
        ce && r_r.st == ODAC_ST_EXEC && cmd_w == ODAC_CMD_ALL |=>
            r_r.dacreg == {N_CH{$past(code_w)}};
    endproperty
    a_all_full: assert property (p_all_full) else $error("load-all missed one");
endmodule // odac_port
